// [inc/bpd_pkg.sv]
// Package with constants and carrier types for the brownout and power-on detect control.
package bpd_pkg;

  // Power mode codes.
  localparam logic [1:0] BPD_MODE_NORMAL = 2'h0;
  localparam logic [1:0] BPD_MODE_IDLE = 2'h1;
  localparam logic [1:0] BPD_MODE_PDOWN = 2'h2;
  localparam logic [1:0] BPD_MODE_TPDOWN = 2'h3;

  // Register indexes on the plain register port.
  localparam logic [3:0] BPD_REG_POWER_CONTROL = 4'h0;
  localparam logic [3:0] BPD_REG_IRQ_ENABLE0 = 4'h1;
  localparam logic [3:0] BPD_REG_BROWNOUT_CONFIG = 4'h2;
  localparam logic [3:0] BPD_REG_RESET_SOURCE = 4'h3;
  localparam logic [3:0] BPD_REG_IRQ_STATUS = 4'h4;
  localparam logic [3:0] BPD_REG_IRQ_MASK = 4'h5;
  localparam logic [3:0] BPD_REG_LIVE_STATUS = 4'h6;

  // Field positions.
  localparam int BPD_POS_MODE_LO = 0;
  localparam int BPD_POS_MODE_HI = 1;
  localparam int BPD_POS_BROWNOUT_IRQ_ENABLE = 4;
  localparam int BPD_POS_SOURCE_ENABLE = 5;
  localparam int BPD_POS_GLOBAL_ENABLE = 7;
  localparam int BPD_POS_POWER_ON_FLAG = 4;
  localparam int BPD_POS_RESET_FLAG = 5;
  localparam int BPD_POS_IRQ_FLAG = 6;
  localparam int BPD_NVM_TRIP_LSB = 3;

  // Reset values.
  localparam logic [7:0] BPD_RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] BPD_RST_IRQ_ENABLE0 = 8'h00;
  localparam logic [2:0] BPD_RST_IRQ_TRIP = 3'h2;
  localparam logic [2:0] BPD_RST_IRQ_MASK = 3'h0;

  // Lowest usable trip code and number of levels.
  localparam logic [2:0] BPD_TRIP_MIN = 3'h2;
  localparam int BPD_TRIP_LEVELS = 6;

  // Synchroniser depth.
  localparam int BPD_SYNC_STAGES = 2;

  // Event bits in the sticky status and mask registers.
  localparam int BPD_EV_RESET_TRIP = 0;
  localparam int BPD_EV_IRQ_TRIP = 1;
  localparam int BPD_EV_FLASH_TRIP = 2;
  localparam int BPD_EV_COUNT = 3;

  // Comparator outputs from the analog side.
  typedef struct packed {
    logic rst_fall;
    logic rst_rise;
    logic irq_fall;
    logic irq_rise;
    logic flash_fall;
    logic flash_rise;
  } bpd_cmp_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bpd_req_t;

endpackage

// [rtl/bpd_ctrl.sv]
// Brownout and power-on detect control: mode gating, flags, interrupt and reset requests.
//
// Notes on behaviour
// - In power-down (10) or total power-down (11) all three brownout functions are off.
// - In normal or idle mode the brownout reset and flash protection are always on.
// - The brownout interrupt goes out only in normal or idle mode with all three enables set.
// - The reset trip level comes from nonvolatile bits 5 to 3, codes 000 and 001 reserved.
// - The interrupt trip level comes from config bits 2 to 0, codes 000 and 001 reserved.
// - Each of reset and interrupt has exactly six usable levels, each a fall and rise pair.
// - The brownout reset flag sits at reset source bit 5, reset to 0, set when reset trips.
// - The brownout interrupt flag sits at reset source bit 6, reset to 0, set on interrupt trip.
// - While the flash brownout condition holds, flash program and erase are blocked.
// - Flash protection is off whenever the upper mode bit is 1 and software cannot turn it off.
// - A condition asserts on the falling comparator and clears on the rising one or when its detector is disabled.
// - Power-on resets the device and sets a power-on flag that stays until software clears it.
// - Mode codes are 00 normal, 01 idle, 10 power-down, 11 total power-down.
`timescale 1ns/1ps
module bpd_ctrl
  import bpd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Nonvolatile configuration
  input wire logic [7:0] nonvolatile_user_config1,
  // Analog comparators
  input wire bpd_cmp_t cmp,
  // Power-on detector level, high while supply is coming up
  input wire logic power_on_detect,
  // Outputs to the system
  output logic [2:0] reset_trip_sel,
  output logic [2:0] irq_trip_sel,
  output logic [2:0] detector_enable,
  output logic brownout_reset_req,
  output logic brownout_irq,
  output logic flash_pe_block,
  output logic irq
);

  // Reset release.
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Registers.
  logic [7:0] power_control_reg;
  logic [7:0] irq_enable_reg0;
  logic [2:0] brownout_config_reg;
  logic brownout_reset_flag;
  logic brownout_irq_flag;
  logic power_on_flag;
  logic [BPD_EV_COUNT-1:0] irq_status;
  logic [BPD_EV_COUNT-1:0] irq_mask;

  // Decode.
  wire wr_power_control = reg_wr && (reg_addr == BPD_REG_POWER_CONTROL);
  wire wr_ien = reg_wr && (reg_addr == BPD_REG_IRQ_ENABLE0);
  wire wr_cfg = reg_wr && (reg_addr == BPD_REG_BROWNOUT_CONFIG);
  wire wr_src = reg_wr && (reg_addr == BPD_REG_RESET_SOURCE);
  wire wr_sts = reg_wr && (reg_addr == BPD_REG_IRQ_STATUS);
  wire wr_msk = reg_wr && (reg_addr == BPD_REG_IRQ_MASK);

  // Mode decode.
  wire power_mode_hi = power_control_reg[BPD_POS_MODE_HI];
  wire power_mode_lo = power_control_reg[BPD_POS_MODE_LO];
  wire [1:0] power_mode = {power_mode_hi, power_mode_lo};
  // Both power-down codes share the upper bit, so it alone gates the detectors.
  wire mode_active = (power_mode == BPD_MODE_NORMAL) || (power_mode == BPD_MODE_IDLE);
  wire brownout_irq_enable = power_control_reg[BPD_POS_BROWNOUT_IRQ_ENABLE];
  wire brownout_irq_source_enable = irq_enable_reg0[BPD_POS_SOURCE_ENABLE];
  wire global_irq_enable = irq_enable_reg0[BPD_POS_GLOBAL_ENABLE];

  // Reset and flash detectors ignore every software bit except the mode.
  wire [2:0] next_enable = {!power_mode_hi, mode_active, mode_active};

  // Trip level selection; reserved codes are clamped up to the lowest real level.
  wire [2:0] nvm_trip = nonvolatile_user_config1[BPD_NVM_TRIP_LSB +: 3];
  wire [2:0] next_reset_sel = (nvm_trip < BPD_TRIP_MIN) ? BPD_TRIP_MIN : nvm_trip;
  wire [2:0] next_irq_sel = (brownout_config_reg < BPD_TRIP_MIN) ? BPD_TRIP_MIN : brownout_config_reg;

  // Comparator synchronisers.
  bpd_cmp_t cmp_s;
  bpd_sync #(.WIDTH($bits(bpd_cmp_t))) u_sync (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .async_in(cmp),
    .sync_out(cmp_s)
  );

  // Hysteresis: flash is bit 2, interrupt bit 1, reset bit 0.
  logic [2:0] cond;
  bpd_hyst #(.WIDTH(3)) u_hyst (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .enable(detector_enable),
    .below({cmp_s.flash_fall, cmp_s.irq_fall, cmp_s.rst_fall}),
    .above({cmp_s.flash_rise, cmp_s.irq_rise, cmp_s.rst_rise}),
    .cond(cond)
  );

  wire rst_cond = cond[0];
  wire irq_cond = cond[1];
  wire flash_cond = cond[2];

  // Rising edges of conditions are trip events.
  logic [2:0] cond_d;
  wire [2:0] trip = cond & ~cond_d;
  wire irq_deliver = mode_active && brownout_irq_enable && brownout_irq_source_enable
    && global_irq_enable && brownout_irq_flag;

  // Power-on detector is caught after reset release, then held until software clears it.
  wire next_power_on_flag = power_on_detect ? 1'b1 :
    (wr_src && reg_wdata[BPD_POS_POWER_ON_FLAG]) ? 1'b0 : power_on_flag;
  wire next_reset_flag = trip[0] ? 1'b1 :
    (wr_src && reg_wdata[BPD_POS_RESET_FLAG]) ? 1'b0 : brownout_reset_flag;
  wire next_irq_flag = trip[1] ? 1'b1 :
    (wr_src && reg_wdata[BPD_POS_IRQ_FLAG]) ? 1'b0 : brownout_irq_flag;

  wire [BPD_EV_COUNT-1:0] next_status = trip | (irq_status & ~(wr_sts ? reg_wdata[BPD_EV_COUNT-1:0] : '0));

  // Read mux.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      BPD_REG_POWER_CONTROL: rd_mux = power_control_reg;
      BPD_REG_IRQ_ENABLE0: rd_mux = irq_enable_reg0;
      BPD_REG_BROWNOUT_CONFIG: rd_mux = {5'h00, brownout_config_reg};
      BPD_REG_RESET_SOURCE: begin
        rd_mux[BPD_POS_POWER_ON_FLAG] = power_on_flag;
        rd_mux[BPD_POS_RESET_FLAG] = brownout_reset_flag;
        rd_mux[BPD_POS_IRQ_FLAG] = brownout_irq_flag;
      end
      BPD_REG_IRQ_STATUS: rd_mux = {5'h00, irq_status};
      BPD_REG_IRQ_MASK: rd_mux = {5'h00, irq_mask};
      BPD_REG_LIVE_STATUS: rd_mux = {5'h00, cond};
      default: rd_mux = 8'h00;
    endcase
  end

  // Software registers.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      power_control_reg <= BPD_RST_POWER_CONTROL;
      irq_enable_reg0 <= BPD_RST_IRQ_ENABLE0;
      brownout_config_reg <= BPD_RST_IRQ_TRIP;
      irq_mask <= BPD_RST_IRQ_MASK;
    end else begin
      if (wr_power_control) begin
        power_control_reg <= reg_wdata;
      end
      if (wr_ien) begin
        irq_enable_reg0 <= reg_wdata;
      end
      if (wr_cfg) begin
        brownout_config_reg <= reg_wdata[2:0];
      end
      if (wr_msk) begin
        irq_mask <= reg_wdata[BPD_EV_COUNT-1:0];
      end
    end
  end

  // Flags and status: a trip in the clearing cycle wins.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cond_d <= 3'h0;
      brownout_reset_flag <= 1'b0;
      brownout_irq_flag <= 1'b0;
      power_on_flag <= 1'b0;
      irq_status <= '0;
    end else begin
      cond_d <= cond;
      brownout_reset_flag <= next_reset_flag;
      brownout_irq_flag <= next_irq_flag;
      power_on_flag <= next_power_on_flag;
      irq_status <= next_status;
    end
  end

  // Registered outputs.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 8'h00;
      reset_trip_sel <= BPD_TRIP_MIN;
      irq_trip_sel <= BPD_RST_IRQ_TRIP;
      detector_enable <= 3'h7;
      brownout_reset_req <= 1'b0;
      brownout_irq <= 1'b0;
      flash_pe_block <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      reset_trip_sel <= next_reset_sel;
      irq_trip_sel <= next_irq_sel;
      detector_enable <= next_enable;
      brownout_reset_req <= rst_cond;
      brownout_irq <= irq_deliver;
      flash_pe_block <= flash_cond;
      irq <= |(next_status & irq_mask);
    end
  end

endmodule

// [rtl/bpd_hyst.sv]
// Hysteresis latch: set by the falling comparator, cleared by the rising one or by a low enable.
`timescale 1ns/1ps
module bpd_hyst
  import bpd_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_sync_b,
  // Control
  input wire logic [WIDTH-1:0] enable,
  input wire logic [WIDTH-1:0] below,
  input wire logic [WIDTH-1:0] above,
  // Condition
  output logic [WIDTH-1:0] cond
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_ch
      logic next_cond;
      // A disabled detector forgets its condition, matching circuitry that is powered off.
      assign next_cond = !enable[i] ? 1'b0 : below[i] ? 1'b1 : above[i] ? 1'b0 : cond[i];
      always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          cond[i] <= 1'b0;
        end else begin
          cond[i] <= next_cond;
        end
      end
    end
  endgenerate

endmodule

// [rtl/bpd_sync.sv]
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module bpd_sync
  import bpd_pkg::*;
#(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_sync_b,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// [tb/bpd_cmp_model.sv]
// Behavioural model of the analog supply comparators.
`timescale 1ns/1ps
module bpd_cmp_model
  import bpd_pkg::*;
(
  // Trip selection and detector power
  input wire logic [2:0] reset_trip_sel,
  input wire logic [2:0] irq_trip_sel,
  input wire logic [2:0] detector_enable,
  // Supply in millivolts
  input wire logic [15:0] vdd_mv,
  // Comparator levels
  output bpd_cmp_t cmp
);
  // Fall and rise levels in mV by trip code.
  int rf[8] = '{0, 0, 2250, 2550, 2850, 3150, 3850, 4050};
  int rr[8] = '{0, 0, 2400, 2700, 3000, 3300, 4000, 4200};
  int qf[8] = '{0, 0, 2550, 2850, 3000, 3450, 4150, 4350};
  int qr[8] = '{0, 0, 2700, 3000, 3150, 3600, 4300, 4500};
  int v;
  assign v = int'(vdd_mv);
  // An unpowered comparator reports nothing, so a disabled detector never trips.
  // One assignment drives the whole struct, so the carrier has a single driver.
  assign cmp = '{
    rst_fall: detector_enable[0] && v < rf[reset_trip_sel],
    rst_rise: detector_enable[0] && v > rr[reset_trip_sel],
    irq_fall: detector_enable[1] && v < qf[irq_trip_sel],
    irq_rise: detector_enable[1] && v > qr[irq_trip_sel],
    flash_fall: detector_enable[2] && v < 2400,
    flash_rise: detector_enable[2] && v > 2400
  };
endmodule

// [tb/bpd_ctrl_asserts.sv]
// Port-level assertions for the brownout control block.
`timescale 1ns/1ps
module bpd_ctrl_asserts
  import bpd_pkg::*;
(
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Configuration and analog side
  input wire logic [7:0] nonvolatile_user_config1,
  input wire bpd_cmp_t cmp,
  input wire logic power_on_detect,
  // Block outputs
  input wire logic [2:0] reset_trip_sel,
  input wire logic [2:0] irq_trip_sel,
  input wire logic [2:0] detector_enable,
  input wire logic brownout_irq,
  input wire logic flash_pe_block
);
  logic [7:0] pc;
  logic [7:0] ien;
  logic [2:0] up;
  logic pwr_on_q;
  wire live = up == 3'h7;
  wire ok = !pc[1] && pc[4] && ien[5] && ien[7];
  wire [2:0] nv = nonvolatile_user_config1[5:3];
  wire pc_wr = reg_wr && reg_addr == BPD_REG_POWER_CONTROL;
  wire rs_clr = reg_wr && reg_addr == BPD_REG_RESET_SOURCE && reg_wdata[BPD_POS_POWER_ON_FLAG];
  // Shadow registers let the mode gating be judged from the ports alone.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc <= 8'h00;
      ien <= 8'h00;
      up <= 3'h0;
      pwr_on_q <= 1'b0;
    end else begin
      pc <= pc_wr ? reg_wdata : pc;
      ien <= (reg_wr && reg_addr == BPD_REG_IRQ_ENABLE0) ? reg_wdata : ien;
      up <= live ? up : up + 3'h1;
      pwr_on_q <= rs_clr ? 1'b0 : (pwr_on_q | $past(power_on_detect, 4));
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence flash_low_s;
    (cmp.flash_fall && !pc[1]) [*6];
  endsequence
  sequence flash_quiet_s;
    (!cmp.flash_rise && !pc[1]) [*5];
  endsequence
  pdown_off_a: assert property (pc_wr && reg_wdata[1] |-> ##2 detector_enable == 3'h0)
    else $error("detectors powered in power-down");
  run_on_a: assert property (pc_wr && !reg_wdata[1] |-> ##2 (detector_enable[2] && detector_enable[0]))
    else $error("reset or flash detector off in run mode");
  trip_range_a: assert property (reset_trip_sel >= BPD_TRIP_MIN && irq_trip_sel >= BPD_TRIP_MIN)
    else $error("reserved trip code selected");
  rst_sel_a: assert property (live && $stable(nv) [*3] |-> reset_trip_sel == ((nv < BPD_TRIP_MIN) ? BPD_TRIP_MIN : nv))
    else $error("reset trip code not taken from config");
  irq_gate_a: assert property (brownout_irq |-> ok || $past(ok))
    else $error("brownout irq without all enables");
  flash_trip_a: assert property (flash_low_s |-> flash_pe_block)
    else $error("flash not blocked under low supply");
  flash_hold_a: assert property (flash_quiet_s ##0 $past(flash_pe_block) |-> flash_pe_block)
    else $error("flash block dropped without rise");
  power_on_keep_a: assert property (reg_rd && reg_addr == BPD_REG_RESET_SOURCE && pwr_on_q |=> reg_rdata[4])
    else $error("power-on flag lost");
endmodule

// [tb/tb_top.sv]
// Self-checking testbench for the brownout control block.
`timescale 1ns/1ps
module tb_top;
  import bpd_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] nvm = 8'h10;
  logic power_on_detect = 1'b1;
  logic [15:0] vdd_mv = 16'd3300;
  bpd_cmp_t cmp;
  logic [2:0] reset_trip_sel;
  logic [2:0] irq_trip_sel;
  logic [2:0] detector_enable;
  logic brownout_reset_req;
  logic brownout_irq;
  logic flash_pe_block;
  logic irq;
  int bad_count = 0;
  int compares = 0;
  bpd_ctrl DUT (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nonvolatile_user_config1(nvm), .cmp, .power_on_detect, .reset_trip_sel, .irq_trip_sel,
    .detector_enable, .brownout_reset_req, .brownout_irq, .flash_pe_block, .irq);
  bpd_cmp_model PM (.reset_trip_sel, .irq_trip_sel, .detector_enable, .vdd_mv, .cmp);
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Flags in order: reset request, brownout irq, flash block, irq.
  task automatic outs(input logic [3:0] e);
    chk("flags", {4'h0, e}, {4'h0, brownout_reset_req, brownout_irq, flash_pe_block, irq});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic supply(input int mv);
    @(posedge mclk);
    vdd_mv <= 16'(mv);
    step(8);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task automatic t_reset();
    outs(4'h0);
    chk("trip_sel", 8'h12, {2'h0, reset_trip_sel, irq_trip_sel});
    chk("det_en", 8'h07, {5'h0, detector_enable});
    rd("power_control", BPD_REG_POWER_CONTROL, BPD_RST_POWER_CONTROL);
    wr(4'hF, 8'hFF);
    rd("unmapped", 4'hF, 8'h00);
    rd("rsrc", BPD_REG_RESET_SOURCE, 8'h10);
    wr(BPD_REG_RESET_SOURCE, 8'h10);
    rd("rsrc", BPD_REG_RESET_SOURCE, 8'h00);
  endtask
  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      @(posedge mclk);
      nvm <= {2'h0, 3'(c), 3'h0};
      wr(BPD_REG_BROWNOUT_CONFIG, 8'(c));
      step(3);
      chk("trip_sel", (c < 2) ? 8'h12 : 8'(c * 9), {2'h0, reset_trip_sel, irq_trip_sel});
    end
    @(posedge mclk);
    nvm <= 8'h10;
    wr(BPD_REG_BROWNOUT_CONFIG, 8'h02);
    // The high codes trip both detectors at the nominal supply; clear what they left behind.
    rd("reset_source", BPD_REG_RESET_SOURCE, 8'h60);
    rd("irq_status", BPD_REG_IRQ_STATUS, 8'h03);
    wr(BPD_REG_RESET_SOURCE, 8'h60);
    wr(BPD_REG_IRQ_STATUS, 8'h07);
  endtask
  task automatic t_flash();
    wr(BPD_REG_IRQ_MASK, 8'h07);
    supply(2300);
    outs(4'h3);
    rd("rsrc", BPD_REG_RESET_SOURCE, 8'h40);
    rd("status", BPD_REG_IRQ_STATUS, 8'h06);
    supply(2400);
    outs(4'h3);
    supply(2200);
    rd("rsrc", BPD_REG_RESET_SOURCE, 8'h60);
    supply(2300);
    outs(4'hB);
    supply(3300);
    outs(4'h1);
    wr(BPD_REG_RESET_SOURCE, 8'h60);
    wr(BPD_REG_IRQ_STATUS, 8'h07);
    step(2);
    outs(4'h0);
  endtask
  task automatic t_irq();
    wr(BPD_REG_IRQ_MASK, 8'h00);
    wr(BPD_REG_POWER_CONTROL, 8'h11);
    wr(BPD_REG_IRQ_ENABLE0, 8'hA0);
    supply(2500);
    outs(4'h4);
    wr(BPD_REG_IRQ_MASK, 8'h07);
    step(2);
    outs(4'h5);
    wr(BPD_REG_IRQ_ENABLE0, 8'h20);
    step(2);
    outs(4'h1);
    wr(BPD_REG_IRQ_ENABLE0, 8'h80);
    step(2);
    outs(4'h1);
    wr(BPD_REG_IRQ_ENABLE0, 8'hA0);
    wr(BPD_REG_POWER_CONTROL, 8'h01);
    step(2);
    outs(4'h1);
  endtask
  task automatic t_pdown();
    for (int m = 2; m < 4; m++) begin
      wr(BPD_REG_POWER_CONTROL, 8'h10 | 8'(m));
      supply(2000);
      chk("det_en", 8'h00, {5'h0, detector_enable});
      outs(4'h0);
    end
    wr(BPD_REG_POWER_CONTROL, 8'h10);
    step(10);
    outs(4'hF);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The whole run needs well under a tenth of this span.
  initial begin
    #40000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    power_on_detect <= 1'b0;
    step(4);
    t_reset();
    t_codes();
    t_flash();
    wr(BPD_REG_RESET_SOURCE, 8'h00);
    t_irq();
    supply(3300);
    wr(BPD_REG_RESET_SOURCE, 8'h40);
    wr(BPD_REG_IRQ_STATUS, 8'h07);
    t_pdown();
    print_verdict();
  end
endmodule
bind bpd_ctrl bpd_ctrl_asserts assert_i (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .nonvolatile_user_config1, .cmp, .power_on_detect, .reset_trip_sel, .irq_trip_sel, .detector_enable,
  .brownout_irq, .flash_pe_block);
